/* tec_channel.sv */
/*
 * One 16-bit timer channel: timer mode and event counter mode, with
 * optional two-phase counting when built as the third channel.
 * Assumes pins and the subclock arrive asynchronously, neighbour and
 * second-group overflow pulses come from logic on clk, and software
 * drives the control ports as plain levels plus a write strobe.
 */
`timescale 1ns/10ps

// Contract
// - Each channel holds its own 16-bit counter and runs independently.
// - Two lowest mode bits choose timer or event counter mode.
// - Timer mode decrements on undivided, div8, div32 or subclock div32 source.
// - Timer underflow reloads from reload register, continues, raises interrupt.
// - Timer underflow period is set value plus one source periods.
// - Counter runs while start flag is 1, stops when cleared.
// - Reading the timer register returns the current count.
// - Write while stopped updates reload register and counter.
// - Write while counting updates reload only; counter takes it at reload.
// - With gate selected, input pin level starts and stops timer counting.
// - With pulse output in timer mode, output pin inverts at each underflow.
// - Event mode counts selected input pin edges or another timer's overflow.
// - Single-phase direction comes from software or the output pin input.
// - Event mode reloads on overflow or underflow unless free-run.
// - Free-run event mode rolls over without reloading.
// - Event ratio is FFFF minus value plus one up, value plus one down.
// - Event mode raises interrupt at every overflow and underflow.
// - Pulse output in event mode inverts output pin at each wrap; pin is driven only in single-phase with software direction.
// - Only the third channel supports two-phase counting.
// - Two-phase takes phases on input and output pins; relation sets direction.
// - Two-phase counts up on phase A rise, down on fall, while B high.
// - Two-phase mode reloads on each wrap unless free-run.
module tec_channel #(
    parameter bit QUAD_CAPABLE = 1'b0                 // Third channel only
) (
    input  wire logic                 clk,            // 125 MHz clock
    input  wire logic                 resetn,         // Async reset, low
    input  wire logic [1:0]           mode_sel,       // Mode register bits 1:0
    input  wire logic                 count_start,    // Count start flag
    input  wire logic [1:0]           src_sel,        // Timer count source
    input  wire logic                 gate_en,        // Gate function on
    input  wire logic                 gate_high,      // Gate counts on high pin
    input  wire logic                 pulse_en,       // Pulse output function
    input  wire logic [1:0]           evt_sel,        // Event source select
    input  wire logic                 evt_fall,       // Count falling edges
    input  wire logic                 dir_ext,        // Direction from pin
    input  wire logic                 dir_up,         // Software direction up
    input  wire logic                 free_run,       // Free-run count
    input  wire logic                 two_phase_en,   // Two-phase processing
    input  wire logic                 tmr_wr,         // Timer register write
    input  wire logic [15:0]          tmr_wdata,      // Write data
    output logic [15:0]               tmr_rdata,      // Current count
    output logic [15:0]               reload_value,   // Reload register
    output logic                      irq,            // Interrupt request pulse
    output logic                      overflow,       // Wrap pulse for others
    input  wire logic                 channel_input_pin,     // Gate/event/phase A
    input  wire logic                 channel_output_pin_i,  // Dir select/phase B
    output logic                      channel_output_pin_o,  // Pulse output
    output logic                      channel_output_pin_oe, // High while driving
    input  wire logic                 neighbour_channel_ovf, // Pulse on clk
    input  wire logic                 second_group_timer_two_ovf, // Pulse on clk
    input  wire logic                 subclock_div32         // Async subclock
);
    import tec_pkg::*;

    logic [SYN_N-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_prev_reg;
    logic [SYN_N-1:0] s1_next, s2_next, s3_next, filt_next;
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic [15:0]      cnt_reg, cnt_next, rld_reg, rld_next;
    logic             irq_reg, irq_next, out_reg, out_next, oe_reg, oe_next;
    logic             in_rise, in_fall, sub_rise, src_tick, gate_ok;
    logic             step, step_up, wrap, is_timer, is_event, quad_on;

    // Three-stage synchronisers; a change is taken once stages 2 and 3 agree
    always_comb begin
        s1_next   = {subclock_div32, channel_output_pin_i, channel_input_pin};
        s2_next   = s1_reg;
        s3_next   = s2_reg;
        filt_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg        <= SYN_RST;
            s2_reg        <= SYN_RST;
            s3_reg        <= SYN_RST;
            filt_reg      <= SYN_RST;
            filt_prev_reg <= SYN_RST;
        end else begin
            s1_reg        <= s1_next;
            s2_reg        <= s2_next;
            s3_reg        <= s3_next;
            filt_reg      <= filt_next;
            filt_prev_reg <= filt_reg;
        end
    end

    // Edges of the filtered levels
    assign in_rise  = filt_reg[SYN_IN] & ~filt_prev_reg[SYN_IN];
    assign in_fall  = ~filt_reg[SYN_IN] & filt_prev_reg[SYN_IN];
    assign sub_rise = filt_reg[SYN_SUB] & ~filt_prev_reg[SYN_SUB];

    // Free-running prescaler; shared taps keep div8 and div32 phase-aligned
    always_comb begin
        pre_next = pre_reg + 5'h01;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // Timer source tick select
    always_comb begin
        case (src_sel)
            SRC_UNDIV: src_tick = 1'b1;
            SRC_DIV8:  src_tick = (pre_reg[2:0] == PRE_LOW8);
            SRC_DIV32: src_tick = (pre_reg == PRE_DIV32);
            SRC_SUB32: src_tick = sub_rise;
            default:   src_tick = 1'b0;
        endcase
    end

    // Mode decode; two-phase exists only on the quad-capable build
    assign is_timer = (mode_sel == MODE_TIMER);
    assign is_event = (mode_sel == MODE_EVENT);
    assign quad_on  = QUAD_CAPABLE & two_phase_en;
    assign gate_ok  = ~gate_en | (filt_reg[SYN_IN] == gate_high);

    // Count step and direction for the selected mode
    always_comb begin
        step    = 1'b0;
        step_up = 1'b0;
        if (!count_start) begin
            step = 1'b0;
        end else if (is_timer) begin
            step    = src_tick & gate_ok;
            step_up = 1'b0;
        end else if (is_event && quad_on) begin
            // Phase A edges count only while phase B is high
            step    = (in_rise | in_fall) & filt_reg[SYN_OUT];
            step_up = in_rise;
        end else if (is_event) begin
            case (evt_sel)
                EVT_PIN:   step = evt_fall ? in_fall : in_rise;
                EVT_NEIGH: step = neighbour_channel_ovf;
                EVT_GRP2:  step = second_group_timer_two_ovf;
                default:   step = 1'b0;
            endcase
            step_up = dir_ext ? filt_reg[SYN_OUT] : dir_up;
        end
    end

    // Wrap: underflow from zero or overflow from FFFF
    assign wrap = step & (step_up ? (cnt_reg == CNT_MAX) : (cnt_reg == CNT_ZERO));

    // Counter, reload register, interrupt and pulse output next state
    always_comb begin
        cnt_next = cnt_reg;
        rld_next = rld_reg;
        irq_next = 1'b0;
        out_next = out_reg;
        oe_next  = pulse_en & (is_timer | (is_event & ~dir_ext & ~quad_on));
        if (step) begin
            if (wrap) begin
                irq_next = 1'b1;
                if (pulse_en) begin
                    out_next = ~out_reg;
                end
                if (is_event && free_run) begin
                    cnt_next = step_up ? CNT_ZERO : CNT_MAX;
                end else begin
                    cnt_next = rld_reg;
                end
            end else if (step_up) begin
                cnt_next = cnt_reg + 16'h0001;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end
        if (tmr_wr) begin
            rld_next = tmr_wdata;
            if (!count_start) begin
                cnt_next = tmr_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= CNT_ZERO;
            rld_reg <= RELOAD_RST;
            irq_reg <= 1'b0;
            out_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            rld_reg <= rld_next;
            irq_reg <= irq_next;
            out_reg <= out_next;
            oe_reg  <= oe_next;
        end
    end

    // Outputs are flops; the read port is the live counter
    assign tmr_rdata             = cnt_reg;
    assign reload_value          = rld_reg;
    assign irq                   = irq_reg;
    assign overflow              = irq_reg;
    assign channel_output_pin_o  = out_reg;
    assign channel_output_pin_oe = oe_reg;

    // Stopped channel holds its count unless software writes it
    a_stop_holds_count: assert property (@(posedge clk) disable iff (!resetn)
        (!count_start && !tmr_wr) |=> (cnt_reg == $past(cnt_reg)))
        else $error("count moved while stopped");

    a_stop_no_irq: assert property (@(posedge clk) disable iff (!resetn)
        !count_start |=> (!irq && (channel_output_pin_o == $past(channel_output_pin_o))))
        else $error("irq or toggle while stopped");

    a_timer_decrement: assert property (@(posedge clk) disable iff (!resetn)
        (count_start && is_timer && step && cnt_reg != CNT_ZERO)
        |=> (cnt_reg == $past(cnt_reg) - 16'h0001))
        else $error("timer did not decrement");

    a_timer_reload_irq: assert property (@(posedge clk) disable iff (!resetn)
        (count_start && is_timer && step && cnt_reg == CNT_ZERO && !tmr_wr)
        |=> (irq && cnt_reg == $past(rld_reg)))
        else $error("underflow missed reload or irq");

    a_write_stopped: assert property (@(posedge clk) disable iff (!resetn)
        (tmr_wr && !count_start)
        |=> (cnt_reg == $past(tmr_wdata) && rld_reg == $past(tmr_wdata)))
        else $error("stopped write not applied to both");

    a_write_running: assert property (@(posedge clk) disable iff (!resetn)
        (tmr_wr && count_start && !step)
        |=> (rld_reg == $past(tmr_wdata) && cnt_reg == $past(cnt_reg)))
        else $error("running write touched counter");

    a_gate_blocks: assert property (@(posedge clk) disable iff (!resetn)
        (is_timer && gate_en && filt_reg[SYN_IN] != gate_high && !tmr_wr)
        |=> (cnt_reg == $past(cnt_reg)))
        else $error("gate closed but timer counted");

    a_pulse_toggle: assert property (@(posedge clk) disable iff (!resetn)
        (wrap && pulse_en) |=> (channel_output_pin_o != $past(channel_output_pin_o)) && irq)
        else $error("wrap without toggle");

    a_free_run_roll: assert property (@(posedge clk) disable iff (!resetn)
        (is_event && free_run && step && step_up && cnt_reg == CNT_MAX && !tmr_wr)
        |=> (cnt_reg == CNT_ZERO))
        else $error("free-run overflow did not roll to zero");

    a_quad_up: assert property (@(posedge clk) disable iff (!resetn)
        (count_start && is_event && quad_on && in_rise && filt_reg[SYN_OUT]
         && cnt_reg != CNT_MAX && !tmr_wr)
        |=> (cnt_reg == $past(cnt_reg) + 16'h0001))
        else $error("two-phase up count missed");

    // Prescaled sources step only on their shared tap
    a_prescale_gap: assert property (@(posedge clk) disable iff (!resetn)
        (is_timer && !tmr_wr
         && ((src_sel == SRC_DIV8 && pre_reg[2:0] != PRE_LOW8)
          || (src_sel == SRC_DIV32 && pre_reg != PRE_DIV32)))
        |=> (cnt_reg == $past(cnt_reg)))
        else $error("timer stepped between prescaler ticks");

    // Event and two-phase counting: steps, wraps and reloads
    a_event_up: assert property (@(posedge clk) disable iff (!resetn)
        (is_event && step && step_up && cnt_reg != CNT_MAX)
        |=> (cnt_reg == $past(cnt_reg) + 16'h0001))
        else $error("event up count missed");

    a_event_down: assert property (@(posedge clk) disable iff (!resetn)
        (is_event && step && !step_up && cnt_reg != CNT_ZERO)
        |=> (cnt_reg == $past(cnt_reg) - 16'h0001))
        else $error("event down count missed");

    // Old reload value wins even if a write lands on the wrap cycle
    a_event_reload: assert property (@(posedge clk) disable iff (!resetn)
        (is_event && !free_run && wrap)
        |=> (irq && cnt_reg == $past(rld_reg)))
        else $error("event wrap missed reload or irq");

    a_free_run_under: assert property (@(posedge clk) disable iff (!resetn)
        (is_event && free_run && step && !step_up && cnt_reg == CNT_ZERO)
        |=> (cnt_reg == CNT_MAX))
        else $error("free-run underflow did not roll to top");

    a_quad_down: assert property (@(posedge clk) disable iff (!resetn)
        (count_start && is_event && quad_on && in_fall && filt_reg[SYN_OUT]
         && cnt_reg != CNT_ZERO && !tmr_wr)
        |=> (cnt_reg == $past(cnt_reg) - 16'h0001))
        else $error("two-phase down count missed");

    a_quad_b_low: assert property (@(posedge clk) disable iff (!resetn)
        (is_event && quad_on && !filt_reg[SYN_OUT] && !tmr_wr)
        |=> (cnt_reg == $past(cnt_reg)))
        else $error("two-phase counted with phase B low");

    a_reload_write: assert property (@(posedge clk) disable iff (!resetn)
        tmr_wr |=> (reload_value == $past(tmr_wdata)))
        else $error("write did not reach reload register");

endmodule : tec_channel

/* tec_far_model.sv */
/*
 * Far side of one timer channel: input pin, output pin used as an
 * input, neighbour and second-group overflow pulses, free subclock.
 * Assumes tasks are called just after a rising edge of clk.
 */
`timescale 1ns/10ps
module tec_far_model (
    input  wire logic clk,      // Design clock
    input  wire logic b_oe,     // Design drives output pin
    input  wire logic b_o,      // Design pulse output level
    output logic      pin_a,    // Channel input pin
    output logic      pin_b,    // Resolved output pin level
    output logic      nb_ovf,   // Neighbour overflow pulse
    output logic      grp_ovf,  // Second group overflow pulse
    output logic      sub_clk   // Subclock, free running
);
    logic b_drive;              // Our level on the output pin

    // Quiet pins at time zero
    initial begin
        pin_a = 1'b0;
        b_drive = 1'b0;
        nb_ovf = 1'b0;
        grp_ovf = 1'b0;
        sub_clk = 1'b0;
    end

    // Odd period keeps the subclock out of phase with clk
    always #52.5 sub_clk = ~sub_clk;

    // Design wins the pin when it drives, else it is our input
    assign pin_b = b_oe ? b_o : b_drive;

    // Pin moves, then waits out synchroniser and filter delay
    task automatic set_a(input logic v);
        @(posedge clk);
        pin_a <= v;
        repeat (8) @(posedge clk);
    endtask : set_a

    task automatic set_b(input logic v);
        @(posedge clk);
        b_drive <= v;
        repeat (8) @(posedge clk);
    endtask : set_b

    // One-cycle overflow pulse from a neighbour or group-two timer
    task automatic pulse(input logic grp);
        @(posedge clk);
        if (grp) grp_ovf <= 1'b1;
        else nb_ovf <= 1'b1;
        @(posedge clk);
        nb_ovf <= 1'b0;
        grp_ovf <= 1'b0;
    endtask : pulse
endmodule : tec_far_model

/* tec_pkg.sv */
/*
 * Constants for the timer / event counter channel: mode codes,
 * count source and event source selects, prescaler taps.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tec_pkg;

    // Counter width and wrap values
    localparam int          CNT_W       = 16;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [15:0] RELOAD_RST  = 16'h0000;

    // Operating mode, two lowest mode register bits
    localparam logic [1:0]  MODE_TIMER  = 2'h0;
    localparam logic [1:0]  MODE_EVENT  = 2'h1;

    // Timer mode count source select
    localparam logic [1:0]  SRC_UNDIV   = 2'h0;   // clock_undivided
    localparam logic [1:0]  SRC_DIV8    = 2'h1;   // clock_div8
    localparam logic [1:0]  SRC_DIV32   = 2'h2;   // clock_div32
    localparam logic [1:0]  SRC_SUB32   = 2'h3;   // subclock_div32

    // Event counter source select
    localparam logic [1:0]  EVT_PIN     = 2'h0;   // channel_input_pin edges
    localparam logic [1:0]  EVT_NEIGH   = 2'h1;   // neighbour_channel overflow
    localparam logic [1:0]  EVT_GRP2    = 2'h2;   // second_group_timer_two overflow

    // Prescaler
    localparam int          PRE_W       = 5;
    localparam logic [4:0]  PRE_DIV8    = 5'h07;
    localparam logic [4:0]  PRE_DIV32   = 5'h1F;
    localparam logic [2:0]  PRE_LOW8    = 3'h7;

    // Asynchronous input bit positions in the synchroniser vector
    localparam int          SYN_N       = 3;
    localparam int          SYN_IN      = 0;
    localparam int          SYN_OUT     = 1;
    localparam int          SYN_SUB     = 2;
    localparam logic [2:0]  SYN_RST     = 3'h0;

endpackage : tec_pkg

/* tec_tb.sv */
/*
 * Self-checking bench for the timer channel built as the third channel.
 * Assumes tec_pkg, tec_channel and tec_far_model are compiled first.
 */
`timescale 1ns/10ps
module tb;
    import tec_pkg::*;
    logic clk = 1'b0, resetn, count_start, gate_en;
    logic gate_high, pulse_en, evt_fall, dir_ext;
    logic dir_up, free_run, two_phase_en, tmr_wr;
    logic [1:0]  mode_sel, src_sel, evt_sel;
    logic [15:0] tmr_wdata, tmr_rdata, reload_value, v;
    logic        irq, overflow, pin_o, pin_oe, pin_a, pin_b, nb, grp, sub, p;
    int          n_errors = 0, checks = 0, n_irq = 0, cycles = 0, c, k;
    int          mult[3] = '{1, 8, 32};
    logic [15:0] ev[4][4] = '{'{16'h0001, 16'h0000, 16'hFFFD, 16'hFFFD},
                             '{16'h0001, 16'h0001, 16'hFFFD, 16'h0000},
                             '{16'h0000, 16'h0000, 16'h0002, 16'h0002},
                             '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF}};

    tec_channel #(.QUAD_CAPABLE(1'b1)) DUT (.clk(clk), .resetn(resetn),
        .mode_sel(mode_sel), .count_start(count_start), .src_sel(src_sel),
        .gate_en(gate_en), .gate_high(gate_high), .pulse_en(pulse_en),
        .evt_sel(evt_sel), .evt_fall(evt_fall), .dir_ext(dir_ext),
        .dir_up(dir_up), .free_run(free_run), .two_phase_en(two_phase_en),
        .tmr_wr(tmr_wr), .tmr_wdata(tmr_wdata), .tmr_rdata(tmr_rdata),
        .reload_value(reload_value), .irq(irq), .overflow(overflow),
        .channel_input_pin(pin_a), .channel_output_pin_i(pin_b),
        .channel_output_pin_o(pin_o), .channel_output_pin_oe(pin_oe),
        .neighbour_channel_ovf(nb), .second_group_timer_two_ovf(grp),
        .subclock_div32(sub));
    tec_far_model fm (.clk(clk), .b_oe(pin_oe), .b_o(pin_o), .pin_a(pin_a),
        .pin_b(pin_b), .nb_ovf(nb), .grp_ovf(grp), .sub_clk(sub));

    // 125 MHz clock
    always #4 clk = ~clk;

    // Interrupt tally, overflow mirror and hang guard
    always @(posedge clk) begin
        cycles++;
        if (irq === 1'b1) n_irq++;
        if (resetn && overflow !== irq) check(16'(overflow), 16'(irq));
        if (cycles == 30000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Write strobe, then one settle cycle before anything is read
    task automatic wr(input logic [15:0] d);
        @(posedge clk);
        tmr_wr <= 1'b1;
        tmr_wdata <= d;
        @(posedge clk);
        tmr_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    // Cycles from here to the next interrupt pulse, bounded
    task automatic wait_irq(output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while (irq !== 1'b1 && cyc < 2000);
    endtask : wait_irq

    task automatic run(input logic on);
        @(posedge clk);
        count_start <= on;
        @(posedge clk);
    endtask : run

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // Main sequence; inputs start quiet at time zero
    initial begin
        {resetn, count_start, gate_en, gate_high} <= 4'h0;
        {pulse_en, evt_fall, dir_ext, dir_up} <= 4'h0;
        {free_run, two_phase_en, tmr_wr} <= 3'h0;
        mode_sel <= MODE_TIMER;
        src_sel <= SRC_UNDIV;
        evt_sel <= EVT_PIN;
        tmr_wdata <= 16'h0000;
        repeat (4) @(posedge clk);
        check({tmr_rdata | reload_value}, 16'h0000);
        check({12'h000, irq, overflow, pin_o, pin_oe}, 16'h0000);
        resetn <= 1'b1;
        wr(16'h0003);
        check(tmr_rdata, 16'h0003);
        check(reload_value, 16'h0003);
        pulse_en <= 1'b1;
        run(1'b1);
        // Timer periods per prescaled source, output toggles per wrap
        for (k = 0; k < 3; k++) begin
            src_sel <= 2'(k);
            wait_irq(c);
            p = pin_o;
            wait_irq(c);
            check(16'(c), 16'(4 * mult[k]));
            check(16'(pin_o), {15'h0000, ~p});
        end
        check(16'(pin_oe), 16'h0001);
        src_sel <= SRC_SUB32;
        wait_irq(c);
        wait_irq(c);
        check(16'(c > 20 && c < 100), 16'h0001);
        src_sel <= SRC_UNDIV;
        wr(16'h0001);
        check(reload_value, 16'h0001);
        for (k = 0; k < 3; k++) wait_irq(c);
        check(16'(c), 16'h0002);
        run(1'b0);
        // Let a last wrap pulse be tallied before the snapshot
        @(posedge clk);
        v = tmr_rdata;
        c = n_irq;
        p = pin_o;
        repeat (40) @(posedge clk);
        check(tmr_rdata, v);
        check(16'(n_irq - c), 16'h0000);
        check(16'(pin_o), 16'(p));
        // Gate holds the count while the input pin is low
        wr(16'h0005);
        gate_en <= 1'b1;
        gate_high <= 1'b1;
        run(1'b1);
        repeat (20) @(posedge clk);
        check(tmr_rdata, 16'h0005);
        fm.set_a(1'b1);
        check(16'(tmr_rdata != 16'h0005), 16'h0001);
        run(1'b0);
        gate_en <= 1'b0;
        fm.set_a(1'b0);
        // Event wraps: up/down, reload or free-run, both timer sources
        mode_sel <= MODE_EVENT;
        for (k = 0; k < 4; k++) begin
            run(1'b0);
            evt_sel <= (k < 2) ? EVT_NEIGH : EVT_GRP2;
            dir_up <= ev[k][0][0];
            free_run <= ev[k][1][0];
            wr(ev[k][2]);
            run(1'b1);
            c = n_irq;
            p = pin_o;
            repeat (3) fm.pulse(k >= 2);
            repeat (3) @(posedge clk);
            check(tmr_rdata, ev[k][3]);
            check(16'(n_irq - c), 16'h0001);
            check(16'(pin_o), {15'h0000, ~p});
        end
        // Pin edges, selected edge only
        run(1'b0);
        evt_sel <= EVT_PIN;
        free_run <= 1'b0;
        dir_up <= 1'b1;
        wr(16'h0010);
        run(1'b1);
        fm.set_a(1'b1);
        fm.set_a(1'b0);
        check(tmr_rdata, 16'h0011);
        evt_fall <= 1'b1;
        fm.set_a(1'b1);
        fm.set_a(1'b0);
        check(tmr_rdata, 16'h0012);
        // Direction taken from the output pin
        evt_sel <= EVT_NEIGH;
        dir_ext <= 1'b1;
        fm.set_b(1'b0);
        fm.pulse(1'b0);
        repeat (3) @(posedge clk);
        check(tmr_rdata, 16'h0011);
        fm.set_b(1'b1);
        fm.pulse(1'b0);
        repeat (3) @(posedge clk);
        check(tmr_rdata, 16'h0012);
        // Two-phase: phase B high enables, A rise up, A fall down
        dir_ext <= 1'b0;
        pulse_en <= 1'b0;
        evt_sel <= EVT_PIN;
        two_phase_en <= 1'b1;
        fm.set_a(1'b1);
        check(tmr_rdata, 16'h0013);
        fm.set_a(1'b0);
        check(tmr_rdata, 16'h0012);
        fm.set_b(1'b0);
        fm.set_a(1'b1);
        check(tmr_rdata, 16'h0012);
        complete_run();
    end
endmodule : tb
